// ==== logic/rxs_pkg.sv ====
// rxs_pkg: constants for the receive status word and stop logic.
// assumes a 32-bit classic wishbone slave and a 200 MHz system clock.
package rxs_pkg;
  // register byte offsets
  localparam logic [7:0] RXS_MAC_CONTROL_REG_OFS = 8'h00;
  localparam logic [7:0] RXS_INTERRUPT_STATUS_REG_OFS = 8'h04;
  localparam logic [7:0] RXS_LAST_STATUS_OFS = 8'h08;
  // control register fields
  localparam int RXS_CTL_RECEIVE_GATE = 0;
  localparam int RXS_CTL_PASS_BAD_FRAMES = 1;
  localparam int RXS_CTL_SPEED_10 = 2;
  // interrupt status fields
  localparam int RXS_INT_HALTED = 0;
  localparam int RXS_INT_RX_ERROR = 1;
  localparam int RXS_INT_RECEIVING = 2;
  // status word fields
  localparam int RXS_ST_FILTER_PASS = 31;
  localparam int RXS_ST_FILTER_FAIL = 30;
  localparam int RXS_ST_LEN_HI = 29;
  localparam int RXS_ST_LEN_LO = 16;
  localparam int RXS_ST_ERROR_SUMMARY = 15;
  localparam int RXS_ST_BROADCAST = 13;
  localparam int RXS_ST_FRAME_SIZE_MISMATCH = 12;
  localparam int RXS_ST_RUNT = 11;
  localparam int RXS_ST_MULTICAST = 10;
  localparam int RXS_ST_TOO_LONG = 7;
  localparam int RXS_ST_LATE_COLL = 6;
  localparam int RXS_ST_FRAME_TYPE = 5;
  localparam int RXS_ST_WATCHDOG = 4;
  localparam int RXS_ST_MEDIA_ERR = 3;
  localparam int RXS_ST_DRIBBLE = 2;
  localparam int RXS_ST_CRC_ERR = 1;
  // frame size limits in bytes, plus the 10 Mbps dribble minimum in bits
  localparam logic [13:0] RXS_RUNT_LIMIT = 14'd64;
  localparam logic [13:0] RXS_MAX_LEN = 14'd1518;
  localparam logic [13:0] RXS_WATCHDOG_LEN = 14'd2048;
  localparam logic [13:0] RXS_HEADER_LEN = 14'd14;
  localparam logic [15:0] RXS_TYPE_THRESHOLD = 16'd1500;
  localparam logic [2:0] RXS_DRIBBLE_10M_MIN = 3'd3;
  // reset values
  localparam logic [31:0] RXS_CONTROL_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {RXS_IDLE, RXS_FRAME, RXS_DROP} rxs_state_t;
endpackage

// ==== logic/rxs_status_stop.sv ====
// rxs_status_stop: builds the receive status word per frame and runs the stop handshake.
// assumes frame events from the mac receive path, fifo underrun and full flags from the fifos.
//
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module rxs_status_stop
  import rxs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // receive path
  input wire logic frame_start_i,
  input wire logic byte_valid_i,
  input wire logic frame_end_i,
  input wire logic media_err_i,
  input wire logic late_coll_i,
  input wire logic crc_bad_i,
  input wire logic [2:0] dribble_bits_i,
  input wire logic filter_pass_i,
  input wire logic filter_fail_i,
  input wire logic broadcast_i,
  input wire logic multicast_i,
  input wire logic [15:0] length_type_i,
  input wire logic length_type_valid_i,
  // fifo side
  input wire logic data_underrun_i,
  input wire logic status_underrun_i,
  input wire logic rx_status_full_event_i,
  output logic [31:0] status_word_o,
  output logic status_push_o,
  output logic byte_accept_o,
  output logic frame_drop_o,
  output logic receiver_halted_event_o,
  output logic receiver_error_flag_o
);

  // ----------------------------------------
  // operating notes
  // ----------------------------------------
  // frame interface timing:
  //   frame_start_i taken only in idle with receive_gate set
  //   one byte_valid_i pulse per received byte
  //   byte_valid_i may share the cycle of frame_end_i
  //   that last byte is counted into the length
  //   frame_end_i marks the last cycle of the frame
  //   per-frame inputs are sampled on the frame_end_i cycle:
  //     crc_bad_i, dribble_bits_i, filter_pass_i, filter_fail_i
  //     broadcast_i, multicast_i, length_type_i, length_type_valid_i
  //   media_err_i and late_coll_i are levels, or-ed over the frame
  //   next frame_start_i at least one cycle after frame_end_i
  //
  // status word delivery:
  //   status_push_o one cycle after the frame_end_i cycle
  //   status_word_o holds its value until the next push
  //   push never precedes the last byte_accept_o and shares its cycle when that byte comes on the frame_end_i cycle
  //   a full status queue blocks the push and raises the error flag
  //   runts without pass_bad_frames give frame_drop_o instead
  //   push and drop never share a cycle
  //
  // length handling:
  //   counter saturates at the watchdog length
  //   bytes past that point are not accepted, which truncates the frame
  //   byte_accept_o trails byte_valid_i by one cycle
  //   the too-long flag alone never truncates anything
  //   length mismatch compares the length field with bytes minus 18
  //   only length fields of 1500 or less are compared
  //   type flag needs at least a full header
  //
  // error flags:
  //   crc flag also carries media errors seen during the frame
  //   crc flag is not meaningful for runts or late collisions
  //   dribble flag suppressed under a late collision
  //   dribble flag at 10 Mbps needs the minimum count of bits
  //   error summary is or of runt, too long, late collision and crc
  //   reserved positions are forced to zero in every word
  //
  // stop and restart:
  //   software clears receive_gate to stop reception
  //   a frame in progress is finished before the halt
  //   halted pulse comes once the frame state machine is idle
  //   halted_q resets high, so reset itself gives no pulse
  //   the pulse also sets the halted bit of interrupt status
  //   setting receive_gate again resumes reception
  //   queues may be flushed outside while halted
  //
  // receiver error:
  //   raised by an underrun of either host queue
  //   raised by an overrun of the status queue
  //   reception carries on while the flag stands
  //   sticky until software writes one to clear it
  //   an event in the clear cycle wins over the clear
  //   software must find the cause and recover on its own
  //   an underrun needs a soft reset to resynchronise
  //
  // register map, byte offsets:
  //   0x00 control: receive_gate, pass_bad_frames, 10 Mbps mode
  //   0x04 interrupt status: halted, receiver error, receiving
  //   0x08 last pushed status word, read only
  //   other offsets read zero and ignore writes
  //
  // bus timing:
  //   request taken on a rising edge with cyc, stb and no ack
  //   ack one cycle later, for one cycle only
  //   read data registered and valid with ack
  //   a write lands on the edge that takes the request
  //   the master must drop stb for a cycle between requests
  //   control register honours byte lanes
  //   interrupt status clear uses lane zero only
  //
  // hazards:
  //   gate changes mid-frame do not cut the frame short
  //   status inputs must be stable on the end cycle
  //   a push lost to a full queue is reported, not retried
  //   last status register tracks pushed words only
  //   dropped runts leave the last status register alone
  //   the drop state code is reserved and falls back to idle
  //   all outputs are registered, none are combinational

  // ----------------------------------------
  // state
  // ----------------------------------------
  rxs_state_t state_q;
  logic [31:0] mac_control_reg_q;
  logic [13:0] len_q;
  logic media_err_q;
  logic late_coll_q;
  logic halted_q;
  logic halted_sticky_q;
  logic error_sticky_q;
  logic [31:0] last_status_q;
  logic [31:0] status_d;
  logic [13:0] len_fin;
  logic runt_w;
  logic too_long_w;
  logic mismatch_w;
  logic gate_w;
  logic wb_req_w;
  logic wr_w;
  logic err_evt_w;
  logic halt_evt_w;
  logic [15:0] payload_len_w;
  logic clr_halt_w;
  logic clr_err_w;

  assign gate_w = mac_control_reg_q[RXS_CTL_RECEIVE_GATE];
  assign wb_req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_w = wb_req_w && wb_we_i;

  // write one to clear decode for the interrupt status bits
  assign clr_halt_w = wr_w && wb_adr_i == RXS_INTERRUPT_STATUS_REG_OFS && wb_sel_i[0]
    && wb_dat_i[RXS_INT_HALTED];
  assign clr_err_w = wr_w && wb_adr_i == RXS_INTERRUPT_STATUS_REG_OFS && wb_sel_i[0]
    && wb_dat_i[RXS_INT_RX_ERROR];

  // ----------------------------------------
  // frame tracking
  // ----------------------------------------
  // state walks idle, frame; receive_gate only acts between frames
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= RXS_IDLE;
    end else begin
      case (state_q)
        RXS_IDLE: begin
          if (frame_start_i && gate_w) begin
            state_q <= RXS_FRAME;
          end
        end
        RXS_FRAME: begin
          if (frame_end_i) begin
            state_q <= RXS_IDLE;
          end
        end
        default: begin
          state_q <= RXS_IDLE;
        end
      endcase
    end
  end

  // byte counter saturates at watchdog length; later bytes dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      len_q <= 14'd0;
    end else if (state_q == RXS_IDLE && frame_start_i) begin
      len_q <= 14'd0;
    end else if (state_q == RXS_FRAME && byte_valid_i && len_q < RXS_WATCHDOG_LEN) begin
      len_q <= len_q + 14'd1;
    end
  end

  // error flags latched over the frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      media_err_q <= 1'b0;
      late_coll_q <= 1'b0;
    end else if (state_q == RXS_IDLE) begin
      media_err_q <= 1'b0;
      late_coll_q <= 1'b0;
    end else if (state_q == RXS_FRAME) begin
      media_err_q <= media_err_q | media_err_i;
      late_coll_q <= late_coll_q | late_coll_i;
    end
  end

  // byte accept: truncation beyond watchdog length
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_accept_o <= 1'b0;
    end else begin
      byte_accept_o <= state_q == RXS_FRAME && byte_valid_i && len_q < RXS_WATCHDOG_LEN;
    end
  end

  // ----------------------------------------
  // status word assembly
  // ----------------------------------------
  always_comb begin
    len_fin = len_q;
    if (byte_valid_i && len_q < RXS_WATCHDOG_LEN) begin
      len_fin = len_q + 14'd1;
    end
  end

  assign runt_w = len_fin < RXS_RUNT_LIMIT;
  assign too_long_w = len_fin > RXS_MAX_LEN;
  assign payload_len_w = {2'b00, len_fin} - {2'b00, RXS_HEADER_LEN} - 16'd4;
  assign mismatch_w = length_type_valid_i && length_type_i <= RXS_TYPE_THRESHOLD
    && length_type_i != payload_len_w && !(len_fin == RXS_RUNT_LIMIT);

  always_comb begin
    status_d = 32'h0000_0000; // reserved bits stay zero
    status_d[RXS_ST_FILTER_PASS] = filter_pass_i;
    status_d[RXS_ST_FILTER_FAIL] = filter_fail_i;
    status_d[RXS_ST_LEN_HI:RXS_ST_LEN_LO] = len_fin;
    status_d[RXS_ST_BROADCAST] = broadcast_i;
    status_d[RXS_ST_FRAME_SIZE_MISMATCH] = mismatch_w;
    status_d[RXS_ST_RUNT] = runt_w;
    status_d[RXS_ST_MULTICAST] = multicast_i;
    status_d[RXS_ST_TOO_LONG] = too_long_w;
    status_d[RXS_ST_LATE_COLL] = late_coll_q | late_coll_i;
    status_d[RXS_ST_FRAME_TYPE] = length_type_valid_i && len_fin >= RXS_HEADER_LEN
      && length_type_i > RXS_TYPE_THRESHOLD;
    status_d[RXS_ST_WATCHDOG] = len_fin >= RXS_WATCHDOG_LEN;
    status_d[RXS_ST_MEDIA_ERR] = media_err_q | media_err_i;
    status_d[RXS_ST_DRIBBLE] = !(late_coll_q | late_coll_i) && dribble_bits_i != 3'd0
      && (!mac_control_reg_q[RXS_CTL_SPEED_10] || dribble_bits_i >= RXS_DRIBBLE_10M_MIN);
    status_d[RXS_ST_CRC_ERR] = crc_bad_i | media_err_q | media_err_i;
    status_d[RXS_ST_ERROR_SUMMARY] = status_d[RXS_ST_RUNT] | status_d[RXS_ST_TOO_LONG]
      | status_d[RXS_ST_LATE_COLL] | status_d[RXS_ST_CRC_ERR];
  end

  // push status at frame end, after last data; runts need pass_bad_frames
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_push_o <= 1'b0;
      frame_drop_o <= 1'b0;
      status_word_o <= 32'h0000_0000;
      last_status_q <= 32'h0000_0000;
    end else begin
      status_push_o <= 1'b0;
      frame_drop_o <= 1'b0;
      if (state_q == RXS_FRAME && frame_end_i) begin
        if (runt_w && !mac_control_reg_q[RXS_CTL_PASS_BAD_FRAMES]) begin
          frame_drop_o <= 1'b1;
        end else if (!rx_status_full_event_i) begin
          status_push_o <= 1'b1;
          status_word_o <= status_d;
          last_status_q <= status_d;
        end
      end
    end
  end

  // ----------------------------------------
  // halt and error events
  // ----------------------------------------
  // halted once gate is clear and no frame is in progress
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halted_q <= 1'b1;
      receiver_halted_event_o <= 1'b0;
    end else begin
      halted_q <= !gate_w && state_q == RXS_IDLE;
      receiver_halted_event_o <= halt_evt_w;
    end
  end
  assign halt_evt_w = !gate_w && state_q == RXS_IDLE && !halted_q;

  // overrun when a status word meets a full fifo; reception goes on
  assign err_evt_w = data_underrun_i | status_underrun_i
    | (rx_status_full_event_i && state_q == RXS_FRAME && frame_end_i);

  // sticky flags, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halted_sticky_q <= 1'b0;
      error_sticky_q <= 1'b0;
      receiver_error_flag_o <= 1'b0;
    end else begin
      if (halt_evt_w) begin
        halted_sticky_q <= 1'b1;
      end else if (clr_halt_w) begin
        halted_sticky_q <= 1'b0;
      end
      if (err_evt_w) begin
        error_sticky_q <= 1'b1;
        receiver_error_flag_o <= 1'b1;
      end else if (clr_err_w) begin
        error_sticky_q <= 1'b0;
        receiver_error_flag_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  // control register with byte lanes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mac_control_reg_q <= RXS_CONTROL_RESET;
    end else if (wr_w && wb_adr_i == RXS_MAC_CONTROL_REG_OFS) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          mac_control_reg_q[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
        end
      end
    end
  end

  // one-cycle ack, read data registered; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req_w;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req_w && !wb_we_i) begin
        if (wb_adr_i == RXS_MAC_CONTROL_REG_OFS) begin
          wb_dat_o <= mac_control_reg_q;
        end else if (wb_adr_i == RXS_INTERRUPT_STATUS_REG_OFS) begin
          wb_dat_o <= {29'd0, state_q == RXS_FRAME, error_sticky_q, halted_sticky_q};
        end else if (wb_adr_i == RXS_LAST_STATUS_OFS) begin
          wb_dat_o <= last_status_q;
        end
      end
    end
  end

endmodule

// ==== test/rxs_host_fifo.sv ====
// rxs_host_fifo: host side status queue, counts words, flags full and underrun.
// assumes pushes come from the block, pops and flush from the bench.
`timescale 1ns/1ps
module rxs_host_fifo #(
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic flush_i,
  output logic full_o,
  output logic underrun_o
);
  int cnt_q;
  // occupancy, flush only between stop and re-enable
  always_ff @(posedge clk_i) begin
    underrun_o <= 1'b0;
    if (rst_i || flush_i) begin
      cnt_q <= 0;
    end else if (pop_i && cnt_q == 0) begin
      underrun_o <= 1'b1; // host read past the end
    end else begin
      cnt_q <= cnt_q + int'(push_i) - int'(pop_i);
    end
  end
  assign full_o = (cnt_q == DEPTH);
endmodule

// ==== test/rxs_status_stop_chk.sv ====
// rxs_status_stop_chk: port checks for the status word and stop block.
// assumes one clock domain, reset synchronous and active high.
`timescale 1ns/1ps
module rxs_status_stop_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] status_word_o,
  input wire logic status_push_o,
  input wire logic frame_drop_o,
  input wire logic rx_status_full_event_i,
  input wire logic data_underrun_i,
  input wire logic status_underrun_i,
  input wire logic receiver_halted_event_o,
  input wire logic receiver_error_flag_o
);
  // ----------------
  // checks
  // ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [13:0] len;
  logic [31:0] w;
  assign w = status_word_o;
  assign len = w[29:16];
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_WB_ACK: assert property (s_wb_req |=> s_ack_pulse) else $error("ack not a pulse after request");
  AST_RSV: assert property (status_push_o |-> !w[14] && w[9:8] == 2'b00 && !w[0])
    else $error("reserved status bits set");
  AST_ES: assert property (status_push_o |-> w[15] == (w[11] | w[7] | w[6] | w[1]))
    else $error("error summary wrong");
  AST_SIZE: assert property (status_push_o |-> w[11] == (len < 14'd64) && w[7] == (len > 14'd1518))
    else $error("runt or too long flag wrong");
  AST_WD: assert property (status_push_o |-> len <= 14'd2048 && w[4] == (len == 14'd2048))
    else $error("watchdog flag or cap wrong");
  AST_TYPE: assert property (status_push_o && len < 14'd14 |-> !w[5])
    else $error("frame type set on short frame");
  AST_DRIB: assert property (status_push_o |-> !(w[2] && w[6]))
    else $error("dribble with late collision");
  AST_FULL: assert property (status_push_o |-> !$past(rx_status_full_event_i))
    else $error("push into full status queue");
  AST_ERR: assert property (data_underrun_i || status_underrun_i |-> ##[1:2] receiver_error_flag_o)
    else $error("error flag missing after underrun");
  AST_DROP: assert property (frame_drop_o |-> !status_push_o)
    else $error("dropped runt also pushed");
  AST_HALT: assert property (receiver_halted_event_o |=> !receiver_halted_event_o)
    else $error("halted event not a pulse");
endmodule

// ==== test/rxs_status_stop_tb.sv ====
// rxs_status_stop_tb: frames, register bus, halt and error checks.
// assumes the host fifo model and the port checker beside it.
`timescale 1ns/1ps
module rxs_status_stop_tb;
  import rxs_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, pop = 0, flush = 0;
  logic frame_start_i = 0, byte_valid_i = 0, frame_end_i = 0, media_err_i = 0, late_coll_i = 0;
  logic crc_bad_i = 0, filter_pass_i = 0, filter_fail_i = 0, broadcast_i = 0, multicast_i = 0;
  logic length_type_valid_i = 0, data_underrun_i = 0, status_underrun_i, rx_status_full_event_i;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 0, wb_dat_o, status_word_o, rd, seed = 32'h9158_434f;
  logic [2:0] dribble_bits_i = 0;
  logic [15:0] length_type_i = 0;
  logic wb_ack_o, status_push_o, byte_accept_o, frame_drop_o, receiver_halted_event_o, receiver_error_flag_o;
  logic gate = 0, pb = 0;
  logic [32:0] q[$];
  int n_errors = 0, tests_run = 0, cyc_n = 0, occ = 0, n, acc = 0;
  rxs_status_stop rxs_status_stop_inst (.*);
  rxs_host_fifo #(.DEPTH(4)) rxs_host_fifo_inst (.clk_i(clk_i), .rst_i(rst_i), .push_i(status_push_o),
    .pop_i(pop), .flush_i(flush), .full_o(rx_status_full_event_i), .underrun_o(status_underrun_i));
  // ----------------
  // helpers
  // ----------------
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected word: f = pass, fail, bcast, mcast, late coll, crc, media err
  function automatic logic [31:0] exp_w(int b, logic [15:0] lt, logic [6:0] f, logic [2:0] d);
    logic ru, tl, cr, ty, mm;
    ru = b < 64;
    tl = b > 1518;
    cr = f[1] | f[0];
    ty = lt > 16'd1500 && b >= 14;
    mm = lt <= 16'd1500 && lt != 16'(b - 18);
    return {f[6:5], (b > 2048) ? 14'd2048 : 14'(b), ru | tl | f[2] | cr, 1'b0, f[4], mm, ru, f[3], 2'b00,
      tl, f[2], ty, b >= 2048, f[0], d != 3'd0 && !f[2], cr, 1'b0};
  endfunction
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rst();
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    {gate, pb, occ} = 0;
    @(posedge clk_i);
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // one-cycle strobe: 0 pop, 1 flush, 2 data underrun
  task automatic pulse(input int k);
    @(posedge clk_i);
    if (k == 0) pop <= 1'b1;
    else if (k == 1) flush <= 1'b1;
    else data_underrun_i <= 1'b1;
    @(posedge clk_i);
    {pop, flush, data_underrun_i} <= 3'b000;
  endtask
  task automatic frame(input int b, input logic [15:0] lt, input logic [6:0] f, input logic [2:0] d);
    @(posedge clk_i);
    {frame_start_i, filter_pass_i, filter_fail_i, broadcast_i, multicast_i, late_coll_i} <= {1'b1, f[6:2]};
    {crc_bad_i, media_err_i, dribble_bits_i, length_type_i, length_type_valid_i} <= {f[1:0], d, lt, 1'b1};
    for (int i = 1; i <= b; i++) begin
      @(posedge clk_i) {frame_start_i, byte_valid_i, frame_end_i} <= {2'b01, i == b};
    end
    @(posedge clk_i) {byte_valid_i, frame_end_i, late_coll_i, media_err_i, crc_bad_i} <= 5'h00;
    if (gate && b < 64 && !pb) q.push_back({1'b1, 32'h0000_0000});
    else if (gate && occ < 4) begin
      q.push_back({1'b0, exp_w(b, lt, f, d)});
      occ++;
    end
    repeat (2) @(posedge clk_i);
    chk(33'(acc), gate ? 33'((b > 2048) ? 2048 : b) : 33'h0);
  endtask
  // accepted bytes of the current frame
  always @(posedge clk_i) begin
    if (frame_start_i === 1'b1) acc = 0;
    else if (byte_accept_o === 1'b1) acc++;
  end
  // results leave the block in order; match each against the oldest note
  always @(posedge clk_i) begin
    if (status_push_o === 1'b1 || frame_drop_o === 1'b1) begin
      if (q.size() == 0) chk({frame_drop_o, status_word_o}, 33'h0);
      else chk({frame_drop_o, status_push_o ? status_word_o : 32'h0}, q.pop_front());
    end
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 30000) begin
      n_errors++;
      final_report();
    end
  end
  // ----------------
  // sequence
  // ----------------
  initial begin
    rst();
    wb(1, 8'h00, 32'h0000_0003);
    {gate, pb} = 2'b11;
    for (int k = 0; k < 7; k++) begin
      seed = nxt(seed);
      frame(64 + seed[6:0], 16'h0800, {seed[10:7], 3'b000} | (7'h01 << k), seed[13:11]);
      pulse(0);
      occ = 0;
    end
    frame(10, 16'h0800, 7'h00, 3'd0);
    frame(100, 16'd10, 7'h40, 3'd0);
    frame(1600, 16'h0800, 7'h00, 3'd0);
    frame(2100, 16'h0800, 7'h00, 3'd0);
    frame(80, 16'h0800, 7'h00, 3'd0);
    repeat (3) @(posedge clk_i);
    chk({32'h0, receiver_error_flag_o}, 33'h1);
    wb(1, 8'h00, 32'h0000_0002);
    gate = 0;
    n = 0;
    while (receiver_halted_event_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk({32'h0, receiver_halted_event_o}, 33'h1);
    wb(0, 8'h04, 32'h0);
    chk({1'b0, rd}, 33'h3);
    frame(80, 16'h0800, 7'h00, 3'd0);
    pulse(1);
    wb(1, 8'h04, 32'h0000_0003);
    wb(0, 8'h04, 32'h0);
    chk({1'b0, rd}, 33'h0);
    wb(0, 8'h0c, 32'h0);
    chk({1'b0, rd}, 33'h0);
    wb(0, 8'h08, 32'h0);
    chk({1'b0, rd}, {1'b0, exp_w(2100, 16'h0800, 7'h00, 3'd0)});
    wb(1, 8'h00, 32'h0000_0001);
    gate = 1;
    pb = 0;
    occ = 0;
    frame(20, 16'h0800, 7'h00, 3'd0);
    rst();
    chk({32'h0, receiver_error_flag_o}, 33'h0);
    pulse(2);
    repeat (3) @(posedge clk_i);
    chk({32'h0, receiver_error_flag_o}, 33'h1);
    rst();
    wb(1, 8'h00, 32'h0000_0001);
    gate = 1;
    pulse(0);
    repeat (3) @(posedge clk_i);
    chk({32'h0, receiver_error_flag_o}, 33'h1);
    frame(70, 16'h0800, 7'h60, 3'd0);
    repeat (5) @(posedge clk_i);
    chk(33'(q.size()), 33'h0);
    final_report();
  end
endmodule
bind rxs_status_stop rxs_status_stop_chk rxs_status_stop_chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .status_word_o, .status_push_o, .frame_drop_o, .rx_status_full_event_i, .data_underrun_i, .status_underrun_i,
  .receiver_halted_event_o, .receiver_error_flag_o);
